// ==== chgreg_consts.vh ====
// Constants for the charger identification and limit register bank
`ifndef CHGREG_CONSTS_VH
`define CHGREG_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets (subaddress)
// ----------------------------------------------------------------
`define CHGREG_OFS_ID 8'h00
`define CHGREG_OFS_REV 8'h01
`define CHGREG_OFS_INPUT_CURRENT_CAP 8'h02
`define CHGREG_OFS_TERM 8'h03

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CHGREG_MAKER_MSB 7
`define CHGREG_MAKER_LSB 4
`define CHGREG_MODEL_MSB 3
`define CHGREG_MODEL_LSB 0
`define CHGREG_STEP_MSB 3
`define CHGREG_STEP_LSB 0
`define CHGREG_SPARE_BIT 4
`define CHGREG_ICAP_MSB 3
`define CHGREG_ICAP_LSB 0
`define CHGREG_FLOAT_MSB 7
`define CHGREG_FLOAT_LSB 2
`define CHGREG_VCAP_MSB 1
`define CHGREG_VCAP_LSB 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CHGREG_RST_SPARE 1'h0
`define CHGREG_RST_ICAP 4'h0
`define CHGREG_RST_FLOAT 6'h23
`define CHGREG_RST_VCAP 2'h0

// ----------------------------------------------------------------
// Serial link
// ----------------------------------------------------------------
`define CHGREG_DEV_ADDR 7'h14
`define CHGREG_BITS_PER_BYTE 4'h8

// ----------------------------------------------------------------
// Decode anchors
// ----------------------------------------------------------------
`define CHGREG_FLOAT_LOW_CODE 6'h0f
`define CHGREG_FLOAT_LOW_MV 13'h0ed8
`define CHGREG_FLOAT_STEP_MV 13'h0014

`endif

// ==== chgreg_decode.v ====
// Turns the stored limit codes into milliamp and millivolt figures
`timescale 1ns/10ps
`default_nettype none
`include "chgreg_consts.vh"

module chgreg_decode (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Stored codes
    input wire [3:0] input_current_cap,
    input wire [5:0] float_voltage_code,
    input wire [1:0] charge_voltage_cap,
    // Decoded targets
    output reg [11:0] icap_ma_q,
    output reg [12:0] float_mv_q,
    output reg [12:0] vcap_mv_q
);

    function [11:0] icap_ma;
        input [3:0] code;
        begin
            case (code)
                4'h0: icap_ma = 12'h064; // 100
                4'h1: icap_ma = 12'h096; // 150
                4'h2: icap_ma = 12'h0c8; // 200
                4'h3: icap_ma = 12'h0fa; // 250
                4'h4: icap_ma = 12'h12c; // 300
                4'h5: icap_ma = 12'h190; // 400
                4'h6: icap_ma = 12'h1f4; // 500
                4'h7: icap_ma = 12'h258; // 600
                4'h8: icap_ma = 12'h2bc; // 700
                4'h9: icap_ma = 12'h320; // 800
                4'ha: icap_ma = 12'h384; // 900
                4'hb: icap_ma = 12'h3e8; // 1000
                4'hc: icap_ma = 12'h4b0; // 1200
                4'hd: icap_ma = 12'h5dc; // 1500
                4'he: icap_ma = 12'h708; // 1800
                default: icap_ma = 12'h834; // 2100
            endcase
        end
    endfunction

    function [12:0] float_mv;
        input [5:0] code;
        reg [12:0] steps;
        begin
            steps = {7'h00, code} - {7'h00, `CHGREG_FLOAT_LOW_CODE};
            // Undefined low codes clamp to the lowest defined target
            if (code < `CHGREG_FLOAT_LOW_CODE) begin
                float_mv = `CHGREG_FLOAT_LOW_MV;
            end else if (code <= 6'h2f) begin
                float_mv = `CHGREG_FLOAT_LOW_MV + steps * `CHGREG_FLOAT_STEP_MV;
            end else if (code <= 6'h32) begin
                // Table repeats 4.44 V at the top, so one step is lost here
                float_mv = `CHGREG_FLOAT_LOW_MV + (steps - 13'h0001) * `CHGREG_FLOAT_STEP_MV;
            end else begin
                float_mv = 13'h1194; // 4500
            end
        end
    endfunction

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            icap_ma_q <= 12'h064;
            float_mv_q <= 13'h1068;
            vcap_mv_q <= 13'h0c80;
        end else begin
            icap_ma_q <= icap_ma(input_current_cap);
            float_mv_q <= float_mv(float_voltage_code);
            case (charge_voltage_cap)
                2'h0: vcap_mv_q <= 13'h0c80; // 3200
                2'h1: vcap_mv_q <= 13'h0d48; // 3400
                2'h2: vcap_mv_q <= 13'h0e74; // 3700
                default: vcap_mv_q <= 13'h0ed8; // 3800
            endcase
        end
    end

endmodule
`default_nettype wire

// ==== chgreg_bank.v ====
// Serially reached identification and limit register bank of the charger
// ----------------------------------------------------------------
// Notes on behaviour
// - Offset 0x00 bits 7..4 read a fixed maker code.
// - Offset 0x00 bits 3..0 read a fixed model code the host cannot change.
// - Offset 0x01 bits 3..0 read a fixed silicon step, bits 7..4 unused.
// - Read-only fields ignore writes, read/write fields store and return data.
// - Offset 0x02 bit 4 is a spare read/write bit resetting to 0.
// - Offset 0x02 bits 3..0 hold the input current cap, default 0000 (100 mA).
// - Current cap codes 0000..0111 give 100,150,200,250,300,400,500,600 mA.
// - Current cap codes 1000..1111 give 700,800,900,1000,1200,1500,1800,2100 mA.
// - Offset 0x03 bits 7..2 hold the float voltage code, default 100011 (4.20 V).
// - Float code 001111 is 3.80 V and each step up to 100011 adds 20 mV.
// - Offset 0x03 bits 1..0 hold the charge voltage cap, 3.2/3.4/3.7/3.8 V, default 00.
// - Each written byte is acknowledged and the subaddress advances; reads advance too.
// - All registers return to defaults while the input supply is not valid.
// ----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "chgreg_consts.vh"

module chgreg_bank #(
    // Arbitrary identity values
    parameter [3:0] MAKER_CODE = 4'h5,
    parameter [3:0] MODEL_CODE = 4'h3,
    parameter [3:0] SILICON_STEP = 4'h2,
    parameter [6:0] DEV_ADDR = `CHGREG_DEV_ADDR
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Supply monitor
    input wire supply_ok,
    // Serial link, open drain data
    input wire scl_in,
    input wire sda_in,
    output reg sda_out_q,
    output reg sda_oe_q,
    // Stored fields
    output reg [3:0] input_current_cap_q,
    output reg reserved_spare_bit_q,
    output reg [5:0] float_voltage_code_q,
    output reg [1:0] charge_voltage_cap_q,
    // Decoded targets
    output wire [11:0] icap_ma_q,
    output wire [12:0] float_mv_q,
    output wire [12:0] vcap_mv_q
);

    // ----------------------------------------------------------------
    // Link states
    // ----------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_SUB = 3'h2;
    localparam [2:0] ST_WDAT = 3'h3;
    localparam [2:0] ST_RDAT = 3'h4;
    localparam [2:0] ST_MACK = 3'h5;

    reg [2:0] st_q;
    reg scl_prev_q;
    reg sda_prev_q;
    reg [3:0] cnt_q;
    reg [7:0] sr_q;
    reg [7:0] ptr_q;
    reg ack_q;
    reg rw_q;
    reg mack_q;

    wire scl_rise = scl_in & ~scl_prev_q;
    wire scl_fall = ~scl_in & scl_prev_q;
    wire start_seen = scl_in & scl_prev_q & sda_prev_q & ~sda_in;
    wire stop_seen = scl_in & scl_prev_q & ~sda_prev_q & sda_in;
    wire receiving = (st_q == ST_ADDR) | (st_q == ST_SUB) | (st_q == ST_WDAT);

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    function [7:0] rd_byte;
        input [7:0] ofs;
        begin
            case (ofs)
                `CHGREG_OFS_ID: rd_byte = {MAKER_CODE, MODEL_CODE};
                `CHGREG_OFS_REV: rd_byte = {4'h0, SILICON_STEP};
                `CHGREG_OFS_INPUT_CURRENT_CAP:
                    rd_byte = {3'h0, reserved_spare_bit_q, input_current_cap_q};
                `CHGREG_OFS_TERM: rd_byte = {float_voltage_code_q, charge_voltage_cap_q};
                default: rd_byte = 8'h00;
            endcase
        end
    endfunction

    // First bit to drive when a read byte is loaded
    function rd_top;
        input [7:0] ofs;
        reg [7:0] b;
        begin
            b = rd_byte(ofs);
            rd_top = b[7];
        end
    endfunction

    // ----------------------------------------------------------------
    // Edge history
    // ----------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_prev_q <= 1'h1;
            sda_prev_q <= 1'h1;
            sda_out_q <= 1'h0;
        end else begin
            scl_prev_q <= scl_in;
            sda_prev_q <= sda_in;
            sda_out_q <= 1'h0;
        end
    end

    // ----------------------------------------------------------------
    // Serial engine and register writes
    // ----------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE;
            cnt_q <= 4'h0;
            sr_q <= 8'h00;
            ptr_q <= 8'h00;
            ack_q <= 1'h0;
            rw_q <= 1'h0;
            mack_q <= 1'h0;
            sda_oe_q <= 1'h0;
            reserved_spare_bit_q <= `CHGREG_RST_SPARE;
            input_current_cap_q <= `CHGREG_RST_ICAP;
            float_voltage_code_q <= `CHGREG_RST_FLOAT;
            charge_voltage_cap_q <= `CHGREG_RST_VCAP;
        end else if (!supply_ok) begin
            // Supply loss also drops any transfer in flight
            st_q <= ST_IDLE;
            cnt_q <= 4'h0;
            ptr_q <= 8'h00;
            ack_q <= 1'h0;
            sda_oe_q <= 1'h0;
            reserved_spare_bit_q <= `CHGREG_RST_SPARE;
            input_current_cap_q <= `CHGREG_RST_ICAP;
            float_voltage_code_q <= `CHGREG_RST_FLOAT;
            charge_voltage_cap_q <= `CHGREG_RST_VCAP;
        end else if (start_seen) begin
            st_q <= ST_ADDR;
            cnt_q <= 4'h0;
            ack_q <= 1'h0;
            sda_oe_q <= 1'h0;
        end else if (stop_seen) begin
            st_q <= ST_IDLE;
            ack_q <= 1'h0;
            sda_oe_q <= 1'h0;
        end else if (scl_rise) begin
            if (receiving && !ack_q) begin
                sr_q <= {sr_q[6:0], sda_in};
                cnt_q <= cnt_q + 4'h1;
            end else if (st_q == ST_MACK) begin
                mack_q <= ~sda_in;
            end
        end else if (scl_fall) begin
            if (ack_q) begin
                // Ack slot over: release and move on
                ack_q <= 1'h0;
                sda_oe_q <= 1'h0;
                cnt_q <= 4'h0;
                case (st_q)
                    ST_ADDR: begin
                        if (rw_q) begin
                            st_q <= ST_RDAT;
                            sr_q <= rd_byte(ptr_q);
                            sda_oe_q <= ~rd_top(ptr_q);
                            ptr_q <= ptr_q + 8'h01;
                            cnt_q <= 4'h1;
                        end else begin
                            st_q <= ST_SUB;
                        end
                    end
                    ST_SUB: st_q <= ST_WDAT;
                    default: st_q <= ST_WDAT;
                endcase
            end else if (receiving && cnt_q == `CHGREG_BITS_PER_BYTE) begin
                case (st_q)
                    ST_ADDR: begin
                        if (sr_q[7:1] == DEV_ADDR) begin
                            ack_q <= 1'h1;
                            sda_oe_q <= 1'h1;
                            rw_q <= sr_q[0];
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end
                    ST_SUB: begin
                        ack_q <= 1'h1;
                        sda_oe_q <= 1'h1;
                        ptr_q <= sr_q;
                    end
                    default: begin
                        ack_q <= 1'h1;
                        sda_oe_q <= 1'h1;
                        ptr_q <= ptr_q + 8'h01;
                        // Only writable bits are touched; others stay as they are
                        case (ptr_q)
                            `CHGREG_OFS_INPUT_CURRENT_CAP: begin
                                reserved_spare_bit_q <= sr_q[`CHGREG_SPARE_BIT];
                                input_current_cap_q <= sr_q[`CHGREG_ICAP_MSB:`CHGREG_ICAP_LSB];
                            end
                            `CHGREG_OFS_TERM: begin
                                float_voltage_code_q <=
                                    sr_q[`CHGREG_FLOAT_MSB:`CHGREG_FLOAT_LSB];
                                charge_voltage_cap_q <= sr_q[`CHGREG_VCAP_MSB:`CHGREG_VCAP_LSB];
                            end
                            default: begin
                                sr_q <= sr_q;
                            end
                        endcase
                    end
                endcase
            end else if (st_q == ST_RDAT) begin
                if (cnt_q == `CHGREG_BITS_PER_BYTE) begin
                    st_q <= ST_MACK;
                    sda_oe_q <= 1'h0;
                    mack_q <= 1'h0;
                end else begin
                    sr_q <= {sr_q[6:0], 1'h0};
                    sda_oe_q <= ~sr_q[6];
                    cnt_q <= cnt_q + 4'h1;
                end
            end else if (st_q == ST_MACK) begin
                if (mack_q) begin
                    // Master wants more: next register goes out
                    st_q <= ST_RDAT;
                    sr_q <= rd_byte(ptr_q);
                    sda_oe_q <= ~rd_top(ptr_q);
                    ptr_q <= ptr_q + 8'h01;
                    cnt_q <= 4'h1;
                end else begin
                    st_q <= ST_IDLE;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Code decode
    // ----------------------------------------------------------------
    chgreg_decode u_decode (
        .clk(clk),
        .rst(rst),
        .input_current_cap(input_current_cap_q),
        .float_voltage_code(float_voltage_code_q),
        .charge_voltage_cap(charge_voltage_cap_q),
        .icap_ma_q(icap_ma_q),
        .float_mv_q(float_mv_q),
        .vcap_mv_q(vcap_mv_q)
    );

endmodule
`default_nettype wire

// ==== chgreg_bank_sva.sv ====
// Concurrent checks on the ports of the charger register bank
`timescale 1ns/10ps
`default_nettype none

module chgreg_bank_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Supply and serial link
    input wire logic supply_ok,
    input wire logic scl_in,
    input wire logic sda_out_q,
    input wire logic sda_oe_q,
    // Stored fields and decoded targets
    input wire logic [3:0] input_current_cap_q,
    input wire logic reserved_spare_bit_q,
    input wire logic [5:0] float_voltage_code_q,
    input wire logic [1:0] charge_voltage_cap_q,
    input wire logic [11:0] icap_ma_q,
    input wire logic [12:0] float_mv_q,
    input wire logic [12:0] vcap_mv_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    // Open drain: a high drive value would fight the pull-up
    open_drain_a: assert property (sda_out_q == 1'b0)
        else $error("data drive value not zero");
    supply_dflt_a: assert property (!supply_ok |=> input_current_cap_q == 4'h0
        && !reserved_spare_bit_q && float_voltage_code_q == 6'h23 && charge_voltage_cap_q == 2'h0)
        else $error("fields not default after supply loss");
    oe_scl_low_a: assert property ($changed(sda_oe_q) |-> !scl_in)
        else $error("data drive changed while clock high");
    float_upd_a: assert property ($changed(float_voltage_code_q) |->
        !scl_in || !$past(supply_ok))
        else $error("float code changed outside ack");
    cap_upd_a: assert property ($changed(input_current_cap_q) |->
        !scl_in || !$past(supply_ok))
        else $error("current cap changed outside ack");
    cap_low_a: assert property (input_current_cap_q == 4'h5 |=> icap_ma_q == 12'h190)
        else $error("current decode wrong for low code");
    cap_high_a: assert property (input_current_cap_q == 4'hc |=> icap_ma_q == 12'h4b0)
        else $error("current decode wrong for high code");
    float_base_a: assert property (float_voltage_code_q == 6'h0f |=> float_mv_q == 13'h0ed8)
        else $error("float decode wrong at base code");
    vcap_dec_a: assert property (charge_voltage_cap_q == 2'h2 |=> vcap_mv_q == 13'h0e74)
        else $error("voltage cap decode wrong");
endmodule

bind chgreg_bank chgreg_bank_chk u_chk (.clk(clk), .rst(rst), .supply_ok(supply_ok),
    .scl_in(scl_in), .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q),
    .input_current_cap_q(input_current_cap_q), .reserved_spare_bit_q(reserved_spare_bit_q),
    .float_voltage_code_q(float_voltage_code_q), .charge_voltage_cap_q(charge_voltage_cap_q),
    .icap_ma_q(icap_ma_q), .float_mv_q(float_mv_q), .vcap_mv_q(vcap_mv_q));

`default_nettype wire

// ==== chgreg_host_model.sv ====
// Behavioural serial bus master facing the register bank
`timescale 1ns/10ps
`default_nettype none

module chgreg_host_model (
    // Clock
    input wire logic clk,
    // Serial wires
    output logic scl,
    output logic sda_drv,
    input wire logic sda,
    // Received bytes
    output logic [7:0] got,
    output logic got_stb
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
        got = 8'h00;
        got_stb = 1'b0;
    end
    // ----------------------------------------------------------------
    // Bus phases
    // ----------------------------------------------------------------
    // Data moves only mid-low, two cycles clear of either clock edge
    task automatic phase(input logic b);
        @(posedge clk) scl <= 1'b0;
        got_stb <= 1'b0;
        repeat (2) @(posedge clk);
        sda_drv <= b;
        repeat (2) @(posedge clk);
        scl <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic bit_io(input logic b, output logic r);
        phase(b);
        r = sda;
        @(posedge clk);
    endtask
    task automatic start();
        phase(1'b1);
        sda_drv <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic stop();
        phase(1'b0);
        sda_drv <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic tx_byte(input logic [7:0] d, output logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, nack);
    endtask
    task automatic rx_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        got <= d;
        got_stb <= 1'b1;
        bit_io(last, r);
    endtask
endmodule

`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the charger register bank
`timescale 1ns/10ps
`default_nettype none
`include "chgreg_consts.vh"

module tb_top;
    // Arbitrary identity values
    localparam logic [3:0] MAKER = 4'ha;
    localparam logic [3:0] MODEL = 4'h6;
    localparam logic [3:0] STEP = 4'h7;
    localparam logic [7:0] ADR_W = {`CHGREG_DEV_ADDR, 1'b0};
    logic clk, rst, supply_ok, scl, sda_drv, sda_oe, sda_out, spare, got_stb, nack;
    logic [3:0] icap;
    logic [5:0] fcode, fc;
    logic [1:0] vcap;
    logic [11:0] ima;
    logic [12:0] fmv, vmv;
    logic [7:0] got, d8;
    logic [7:0] exp_q[$];
    logic [31:0] rng;
    logic [11:0] ma_tab [16] = '{12'h064, 12'h096, 12'h0c8, 12'h0fa, 12'h12c, 12'h190,
        12'h1f4, 12'h258, 12'h2bc, 12'h320, 12'h384, 12'h3e8, 12'h4b0, 12'h5dc, 12'h708, 12'h834};
    logic [12:0] vc_tab [4] = '{13'h0c80, 13'h0d48, 13'h0e74, 13'h0ed8};
    logic [5:0] specials [6] = '{6'h0e, 6'h0f, 6'h2f, 6'h30, 6'h32, 6'h33};
    int n_mismatch, total_checks, i;
    wire sda;
    // Pull-up wins unless someone pulls low
    assign sda = sda_drv & ~sda_oe;

    chgreg_bank #(.MAKER_CODE(MAKER), .MODEL_CODE(MODEL), .SILICON_STEP(STEP)) uut (
        .clk(clk), .rst(rst), .supply_ok(supply_ok), .scl_in(scl), .sda_in(sda),
        .sda_out_q(sda_out), .sda_oe_q(sda_oe), .input_current_cap_q(icap),
        .reserved_spare_bit_q(spare), .float_voltage_code_q(fcode),
        .charge_voltage_cap_q(vcap), .icap_ma_q(ima), .float_mv_q(fmv), .vcap_mv_q(vmv));
    chgreg_host_model host (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda(sda),
        .got(got), .got_stb(got_stb));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [12:0] fl_mv(input logic [5:0] c);
        if (c < 6'h0f) return 13'h0ed8;
        if (c <= 6'h2f) return 13'h0ed8 + 13'h0014 * (c - 6'h0f);
        if (c < 6'h33) return 13'h1158 + 13'h0014 * (c - 6'h30);
        return 13'h1194;
    endfunction
    task automatic check(input string what, input logic [12:0] seen, input logic [12:0] want);
        total_checks++;
        if (seen !== want) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic ack_ok(input logic [7:0] b, input logic want);
        host.tx_byte(b, nack);
        check("ack", {12'h000, nack}, {12'h000, want});
    endtask
    // Same byte written n times from one subaddress
    task automatic wr(input logic [7:0] sub, input logic [7:0] d, input int n);
        host.start();
        ack_ok(ADR_W, 1'b0);
        ack_ok(sub, 1'b0);
        for (int k = 0; k < n; k++) ack_ok(d, 1'b0);
        host.stop();
        repeat (3) @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] sub, input int n);
        host.start();
        ack_ok(ADR_W, 1'b0);
        ack_ok(sub, 1'b0);
        host.start();
        ack_ok(ADR_W | 8'h01, 1'b0);
        for (int k = 0; k < n; k++) host.rx_byte(k == n - 1, d8);
        host.stop();
        repeat (3) @(posedge clk);
    endtask
    task automatic check_defaults();
        check("current cap", icap, 13'h0000);
        check("spare bit", spare, 13'h0000);
        check("float code", fcode, 13'h0023);
        check("voltage cap", vcap, 13'h0000);
        check("current mA", ima, 13'h0064);
        check("float mV", fmv, 13'h1068);
        check("cap mV", vmv, 13'h0c80);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Processes
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (got_stb === 1'b1) begin
            if (exp_q.size() == 0) check("extra read", 13'h0001, 13'h0000);
            else check("read byte", {5'h00, got}, {5'h00, exp_q.pop_front()});
        end
    end
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        rst = 1'b1;
        supply_ok = 1'b1;
        n_mismatch = 0;
        total_checks = 0;
        rng = 32'h0000_0005;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        check_defaults();
        $display("test defaults done");
        exp_q = '{{MAKER, MODEL}, {4'h0, STEP}, 8'h00, 8'h8c};
        rd(8'h00, 4);
        $display("test identity read done");
        wr(8'h00, 8'hff, 4);
        exp_q = '{{MAKER, MODEL}, {4'h0, STEP}, 8'h1f, 8'hff, 8'h00};
        rd(8'h00, 5);
        check("current mA", ima, 13'h0834);
        check("float mV", fmv, 13'h1194);
        check("cap mV", vmv, 13'h0ed8);
        $display("test read-only protect done");
        for (i = 0; i < 16; i++) begin
            wr(8'h02, i[7:0], 1);
            check("current mA", ima, ma_tab[i]);
        end
        $display("test current codes done");
        for (i = 0; i < 14; i++) begin
            rng = xs(rng);
            fc = (i < 6) ? specials[i] : rng[7:2];
            wr(8'h03, {fc, rng[1:0]}, 1);
            exp_q.push_back({fc, rng[1:0]});
            rd(8'h03, 1);
            check("float code", fcode, fc);
            check("float mV", fmv, fl_mv(fc));
            check("cap mV", vmv, vc_tab[rng[1:0]]);
        end
        $display("test float codes done");
        host.start();
        ack_ok(ADR_W ^ 8'h7a, 1'b1);
        host.stop();
        $display("test foreign address done");
        supply_ok <= 1'b0;
        repeat (2) @(posedge clk);
        supply_ok <= 1'b1;
        repeat (3) @(posedge clk);
        check_defaults();
        wr(8'h02, 8'h15, 1);
        check("spare bit", spare, 13'h0001);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        check_defaults();
        $display("test supply and reset done");
        end_of_test();
    end
endmodule

`default_nettype wire
